// ==== hdl/pmm_top.sv ====
// Power mode manager: power states, supply gating, radio power-down, LPO wake
`timescale 1ns/1ps
module pmm_top
    import pmm_pkg::*;
#(
    parameter int PERIOD_W       = PERIOD_W_DEF,
    parameter int LPC_WAKE_TICKS = LPC_WAKE_TICKS_DEF
)
(
    input  wire logic          REF_CLK_IN,
    input  wire logic          RST_IN,
    input  wire logic          USER_EVENT_IN,
    input  wire logic [PERIOD_W-1:0] IDLE_PERIOD_IN,
    input  wire pmm_req_t      SW_REQ_IN,
    input  wire pmm_req_t      BB_REQ_IN,
    input  wire pmm_rf_pd_t    SW_RF_PD_IN,
    input  wire pmm_rf_pd_t    BB_RF_PD_IN,
    input  wire logic          PKT_DYN_EN_IN,
    input  wire logic          PKT_TX_ON_IN,
    input  wire logic          PKT_RX_ON_IN,
    input  wire logic          FW_REG_OFF_EN_IN,
    input  wire logic          LPC_ENTER_IN,
    output pmm_state_t         STATE_OUT,
    output pmm_supply_t        SUPPLY_OUT,
    output pmm_rf_pd_t         RF_PD_OUT,
    output logic               LPO_MODE_OUT,
    output logic               LPC_WAKE_OUT,
    output logic               IO_WAKE_OUT
);

    localparam logic [LPO_DIV_W-1:0]  LPO_DIV_LAST = LPO_DIV_W'(LPO_DIV_CYCLES - 1);
    localparam logic [LPC_TICK_W-1:0] LPC_LAST     = LPC_TICK_W'(LPC_WAKE_TICKS - 1);

    // ------------------------------------------------------------------
    // User activity input, kept in the always-on io-supply domain
    // ------------------------------------------------------------------
    logic activity;

    // Activity pin crosses from outside the clock domain
    pmm_sync3 u_act_sync (
        .clk_in    (REF_CLK_IN),
        .rst_in    (RST_IN),
        .pin_in    (USER_EVENT_IN),
        .level_out (activity)
    );

    // ------------------------------------------------------------------
    // Power state machine and inactivity timer
    // ------------------------------------------------------------------
    pmm_state_t          state_ff;
    pmm_state_t          nxt_state;
    logic [PERIOD_W-1:0] idle_cnt_ff;
    logic [PERIOD_W-1:0] nxt_idle_cnt;
    logic                expire;
    logic                wake_req;
    logic                step_req;

    // One step toward lower power; deep off is the floor
    function automatic pmm_state_t lower_state(input pmm_state_t cur);
        pmm_state_t res;
        res = cur;
        unique case (cur)
            PMM_ACTIVE:   res = PMM_IDLE;
            PMM_IDLE:     res = PMM_SLEEP;
            PMM_SLEEP:    res = PMM_DEEP_OFF;
            PMM_DEEP_OFF: res = PMM_DEEP_OFF;
        endcase
        return res;
    endfunction

    // Activity outranks every request so a user never waits on software
    always_comb
    begin
        wake_req     = SW_REQ_IN.wake | BB_REQ_IN.wake;
        step_req     = SW_REQ_IN.step_down | BB_REQ_IN.step_down;
        expire       = (idle_cnt_ff >= IDLE_PERIOD_IN);
        nxt_state    = state_ff;
        if (activity || wake_req)
        begin
            nxt_state = PMM_ACTIVE;
        end
        else if (expire || step_req)
        begin
            nxt_state = lower_state(state_ff);
        end
        // Timer holds at zero in deep off; only activity or a wake request can leave it
        if (activity || (nxt_state != state_ff) || (state_ff == PMM_DEEP_OFF))
        begin
            nxt_idle_cnt = '0;
        end
        else if (!expire)
        begin
            nxt_idle_cnt = idle_cnt_ff + PERIOD_W'(1);
        end
        else
        begin
            nxt_idle_cnt = idle_cnt_ff;
        end
    end

    // ------------------------------------------------------------------
    // Supply gating and radio power-down controls
    // ------------------------------------------------------------------
    pmm_supply_t supply_ff;
    pmm_supply_t nxt_supply;
    pmm_rf_pd_t  rf_pd_ff;
    pmm_rf_pd_t  nxt_rf_pd;
    logic        io_wake_ff;
    logic        nxt_io_wake;

    // Outputs follow the next state so they line up with STATE_OUT
    always_comb
    begin
        nxt_supply.core_supply_en      = (nxt_state != PMM_DEEP_OFF);
        nxt_supply.power_amp_supply_en = (nxt_state != PMM_DEEP_OFF);
        nxt_supply.regulator_en        = !((nxt_state == PMM_DEEP_OFF)
                                           && FW_REG_OFF_EN_IN);
        nxt_io_wake = (state_ff == PMM_DEEP_OFF) && (nxt_state == PMM_ACTIVE);
        nxt_rf_pd   = SW_RF_PD_IN | BB_RF_PD_IN;
        // Within a packet only the path in use stays powered
        if (PKT_DYN_EN_IN)
        begin
            nxt_rf_pd.tx  = nxt_rf_pd.tx  | !PKT_TX_ON_IN;
            nxt_rf_pd.pa  = nxt_rf_pd.pa  | !PKT_TX_ON_IN;
            nxt_rf_pd.rx  = nxt_rf_pd.rx  | !PKT_RX_ON_IN;
            nxt_rf_pd.pll = nxt_rf_pd.pll | !(PKT_TX_ON_IN | PKT_RX_ON_IN);
        end
        if (nxt_state == PMM_DEEP_OFF)
        begin
            nxt_rf_pd = RF_PD_ALL;
        end
    end

    // ------------------------------------------------------------------
    // Low-power connection mode on the LPO tick
    // ------------------------------------------------------------------
    logic [LPO_DIV_W-1:0]  lpo_div_ff;
    logic [LPO_DIV_W-1:0]  nxt_lpo_div;
    logic                  lpo_tick;
    logic                  lpc_ff;
    logic                  nxt_lpc;
    logic [LPC_TICK_W-1:0] lpc_cnt_ff;
    logic [LPC_TICK_W-1:0] nxt_lpc_cnt;
    logic                  lpc_wake_ff;
    logic                  nxt_lpc_wake;

    // Divider runs free, so the first wake tick can come up to one tick early
    always_comb
    begin
        lpo_tick     = (lpo_div_ff == LPO_DIV_LAST);
        nxt_lpo_div  = lpo_tick ? '0 : (lpo_div_ff + LPO_DIV_W'(1));
        nxt_lpc      = lpc_ff;
        nxt_lpc_cnt  = lpc_cnt_ff;
        nxt_lpc_wake = 1'b0;
        if (!lpc_ff && LPC_ENTER_IN && (state_ff != PMM_DEEP_OFF))
        begin
            nxt_lpc     = 1'b1;
            nxt_lpc_cnt = '0;
        end
        else if (lpc_ff && lpo_tick)
        begin
            if (lpc_cnt_ff == LPC_LAST)
            begin
                nxt_lpc      = 1'b0;
                nxt_lpc_wake = 1'b1;
            end
            else
            begin
                nxt_lpc_cnt = lpc_cnt_ff + LPC_TICK_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            state_ff    <= PMM_ACTIVE;
            idle_cnt_ff <= '0;
            supply_ff   <= SUPPLY_RESET;
            rf_pd_ff    <= RF_PD_RESET;
            io_wake_ff  <= 1'b0;
            lpo_div_ff  <= '0;
            lpc_ff      <= 1'b0;
            lpc_cnt_ff  <= '0;
            lpc_wake_ff <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            idle_cnt_ff <= nxt_idle_cnt;
            supply_ff   <= nxt_supply;
            rf_pd_ff    <= nxt_rf_pd;
            io_wake_ff  <= nxt_io_wake;
            lpo_div_ff  <= nxt_lpo_div;
            lpc_ff      <= nxt_lpc;
            lpc_cnt_ff  <= nxt_lpc_cnt;
            lpc_wake_ff <= nxt_lpc_wake;
        end
    end

    assign STATE_OUT    = state_ff;
    assign SUPPLY_OUT   = supply_ff;
    assign RF_PD_OUT    = rf_pd_ff;
    assign LPO_MODE_OUT = lpc_ff;
    assign LPC_WAKE_OUT = lpc_wake_ff;
    assign IO_WAKE_OUT  = io_wake_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_four_states;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        state_ff inside {PMM_ACTIVE, PMM_IDLE, PMM_SLEEP, PMM_DEEP_OFF};
    endproperty
    a_four_states: assert property (p_four_states)
        else $error("state left the four legal power states");

    property p_step_on_expire;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_ff == PMM_ACTIVE && !activity && !wake_req && expire)
            |=> (state_ff == PMM_IDLE && idle_cnt_ff == '0);
    endproperty
    a_step_on_expire: assert property (p_step_on_expire)
        else $error("expired period did not step active to idle");

    property p_activity_wakes;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (activity && state_ff != PMM_ACTIVE) |=> (state_ff == PMM_ACTIVE);
    endproperty
    a_activity_wakes: assert property (p_activity_wakes)
        else $error("activity did not return straight to active");

    property p_deep_supplies;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_ff == PMM_DEEP_OFF)
            |-> (!SUPPLY_OUT.core_supply_en && !SUPPLY_OUT.power_amp_supply_en
                 && RF_PD_OUT == RF_PD_ALL);
    endproperty
    a_deep_supplies: assert property (p_deep_supplies)
        else $error("supplies still on in deep power-off");

    property p_io_wake;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (state_ff == PMM_DEEP_OFF && activity)
            |=> (IO_WAKE_OUT && SUPPLY_OUT.core_supply_en) ##1 !IO_WAKE_OUT;
    endproperty
    a_io_wake: assert property (p_io_wake)
        else $error("user event did not restore power from deep off");

    property p_bb_rf_pd;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (BB_RF_PD_IN.pll && BB_RF_PD_IN.rx) |=> (RF_PD_OUT.pll && RF_PD_OUT.rx);
    endproperty
    a_bb_rf_pd: assert property (p_bb_rf_pd)
        else $error("baseband power-down request not passed to radio");

    property p_pkt_dynamic;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (PKT_DYN_EN_IN && !PKT_TX_ON_IN) |=> (RF_PD_OUT.tx && RF_PD_OUT.pa);
    endproperty
    a_pkt_dynamic: assert property (p_pkt_dynamic)
        else $error("transmit path left powered outside packet transmit");

    property p_lpc_enter;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (!lpc_ff && LPC_ENTER_IN && state_ff != PMM_DEEP_OFF)
            |=> LPO_MODE_OUT && !LPC_WAKE_OUT;
    endproperty
    a_lpc_enter: assert property (p_lpc_enter)
        else $error("low-power connection mode not entered");

    property p_sw_step;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (SW_REQ_IN.step_down && !activity && !wake_req && state_ff == PMM_IDLE)
            |=> (state_ff == PMM_SLEEP);
    endproperty
    a_sw_step: assert property (p_sw_step)
        else $error("software step-down request ignored");

    property p_regulator_off;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (nxt_state == PMM_DEEP_OFF && FW_REG_OFF_EN_IN) |=> !SUPPLY_OUT.regulator_en;
    endproperty
    a_regulator_off: assert property (p_regulator_off)
        else $error("regulator not disabled on deep power-off entry");

    property p_timer_restart;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        (activity || $changed(state_ff)) |-> ##[0:1] (idle_cnt_ff == '0);
    endproperty
    a_timer_restart: assert property (p_timer_restart)
        else $error("inactivity timer not restarted");

    property p_reset_state;
        @(posedge REF_CLK_IN) disable iff (RST_IN)
        $past(RST_IN) |-> (STATE_OUT == PMM_ACTIVE && RF_PD_OUT == RF_PD_RESET);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("wrong state or radio controls after reset");

endmodule

// ==== inc/pmm_pkg.sv ====
// Shared constants and types for the power mode manager
package pmm_pkg;

    // ------------------------------------------------------------------
    // Clock rates and the low-power oscillator tick
    // ------------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ     = 100_000_000;
    localparam int unsigned LPO_CLK_HZ     = 32_768;
    // Nearest whole number of reference cycles per low-power tick
    localparam int unsigned LPO_DIV_CYCLES = (REF_CLK_HZ + (LPO_CLK_HZ / 2)) / LPO_CLK_HZ;
    localparam int          LPO_DIV_W      = 12;
    localparam int          LPC_TICK_W     = 16;
    localparam int          LPC_WAKE_TICKS_DEF = 1024;
    localparam int          PERIOD_W_DEF   = 24;

    // ------------------------------------------------------------------
    // Power states, highest power first
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PMM_ACTIVE,
        PMM_IDLE,
        PMM_SLEEP,
        PMM_DEEP_OFF
    } pmm_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic tx;
        logic rx;
        logic pll;
        logic pa;
    } pmm_rf_pd_t;

    typedef struct packed {
        logic step_down;
        logic wake;
    } pmm_req_t;

    typedef struct packed {
        logic core_supply_en;
        logic power_amp_supply_en;
        logic regulator_en;
    } pmm_supply_t;

    localparam pmm_rf_pd_t  RF_PD_RESET  = 4'h0;
    localparam pmm_rf_pd_t  RF_PD_ALL    = 4'hF;
    localparam pmm_supply_t SUPPLY_RESET = 3'h7;
    localparam logic        SYNC_RESET   = 1'h0;

endpackage

// ==== hdl/pmm_sync3.sv ====
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module pmm_sync3
    import pmm_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);

    logic [2:0] chain_ff;
    logic [2:0] nxt_chain;
    logic       level_ff;
    logic       nxt_level;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    // Stage 0 is read only by stage 1; the filter looks at stages 1 and 2
    always_comb
    begin
        nxt_chain = {chain_ff[1:0], pin_in};
        nxt_level = level_ff;
        if (chain_ff[1] == chain_ff[2])
        begin
            nxt_level = chain_ff[2];
        end
    end

    // Registers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            chain_ff <= {3{SYNC_RESET}};
            level_ff <= SYNC_RESET;
        end
        else
        begin
            chain_ff <= nxt_chain;
            level_ff <= nxt_level;
        end
    end

    assign level_out = level_ff;

endmodule

// ==== dv/pmm_bb_model.sv ====
// Behavioural model of the baseband core driving requests and radio gating
`timescale 1ns/1ps
module pmm_bb_model
    import pmm_pkg::*;
(
    input  wire logic clk_in,
    output pmm_req_t   bb_req_out,
    output pmm_rf_pd_t bb_rf_pd_out,
    output logic       pkt_dyn_en_out,
    output logic       pkt_tx_on_out,
    output logic       pkt_rx_on_out
);
    // ------------------------------------------------------------------
    // Quiet outputs from time zero so reset sees no request
    // ------------------------------------------------------------------
    initial
    begin
        bb_req_out     = 2'h0;
        bb_rf_pd_out   = 4'h0;
        pkt_dyn_en_out = 1'h0;
        pkt_tx_on_out  = 1'h0;
        pkt_rx_on_out  = 1'h0;
    end

    // One-cycle request; a held level would step once per cycle
    task automatic pulse_req(input pmm_req_t r);
        @(posedge clk_in);
        bb_req_out <= r;
        @(posedge clk_in);
        bb_req_out <= 2'h0;
    endtask

    // Radio power-down levels and packet gating; caller sits on an edge
    task automatic set_rf(input pmm_rf_pd_t pd, input logic [2:0] ctl);
        bb_rf_pd_out <= pd;
        {pkt_dyn_en_out, pkt_tx_on_out, pkt_rx_on_out} <= ctl;
    endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking testbench for the power mode manager
`timescale 1ns/1ps
module tb;
    import pmm_pkg::*;
    // ------------------------------------------------------------------
    // Signals and settings
    // ------------------------------------------------------------------
    localparam int P_SHORT = 5;
    localparam int WAKE_TICKS = 2; // Small so the wake period stays short
    typedef struct {logic [3:0] sw; logic [3:0] bb; logic [2:0] ctl; logic [3:0] exp;} pmm_row_t;
    logic        clk     = 1'h0;
    logic        rst     = 1'h1;
    logic        usr_evt = 1'h0;
    logic [23:0] period  = 24'hFFFFFF;
    pmm_req_t    sw_req  = 2'h0;
    pmm_rf_pd_t  sw_pd   = 4'h0;
    logic        fw_off  = 1'h0;
    logic        lpc_en  = 1'h0;
    pmm_req_t    bb_req;
    pmm_rf_pd_t  bb_pd;
    logic        dyn;
    logic        tx_on;
    logic        rx_on;
    pmm_state_t  state;
    pmm_supply_t supply;
    pmm_rf_pd_t  rf_pd;
    logic        lpo_mode;
    logic        lpc_wake;
    logic        io_wake;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          n;
    // Rows: software and baseband requests, {dyn,tx_on,rx_on}, expected
    pmm_row_t    rows [8] = '{'{4'h8, 4'h0, 3'h0, 4'h8}, '{4'h0, 4'h1, 3'h0, 4'h1},
                              '{4'h4, 4'h2, 3'h0, 4'h6}, '{4'h0, 4'h0, 3'h4, 4'hF},
                              '{4'h0, 4'h0, 3'h6, 4'h4}, '{4'h0, 4'h0, 3'h5, 4'h9},
                              '{4'h0, 4'h2, 3'h7, 4'h2}, '{4'h0, 4'h0, 3'h0, 4'h0}};

    always #5 clk = ~clk;

    pmm_bb_model bb (.clk_in(clk), .bb_req_out(bb_req), .bb_rf_pd_out(bb_pd),
        .pkt_dyn_en_out(dyn), .pkt_tx_on_out(tx_on), .pkt_rx_on_out(rx_on));

    pmm_top #(.PERIOD_W(24), .LPC_WAKE_TICKS(WAKE_TICKS)) uut (.REF_CLK_IN(clk),
        .RST_IN(rst), .USER_EVENT_IN(usr_evt), .IDLE_PERIOD_IN(period), .SW_REQ_IN(sw_req),
        .BB_REQ_IN(bb_req), .SW_RF_PD_IN(sw_pd), .BB_RF_PD_IN(bb_pd), .PKT_DYN_EN_IN(dyn),
        .PKT_TX_ON_IN(tx_on), .PKT_RX_ON_IN(rx_on), .FW_REG_OFF_EN_IN(fw_off),
        .LPC_ENTER_IN(lpc_en), .STATE_OUT(state), .SUPPLY_OUT(supply), .RF_PD_OUT(rf_pd),
        .LPO_MODE_OUT(lpo_mode), .LPC_WAKE_OUT(lpc_wake), .IO_WAKE_OUT(io_wake));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Sample 1 ns after the edge so that edge's updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic pulse_sw(input pmm_req_t r);
        @(posedge clk);
        sw_req <= r;
        @(posedge clk);
        sw_req <= 2'h0;
        #1;
    endtask

    // Bounded wait; k returns the edges seen before the state appeared
    task automatic wait_state(input pmm_state_t s, output int k);
        k = 0;
        while (state !== s && k < 50)
        begin
            tick(1);
            k++;
        end
        check(state, s);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run is some 6k cycles; the 80k-cycle limit leaves a wide margin
    initial
    begin
        #800_000;
        miscompares++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        tick(1);
        check(state, PMM_ACTIVE);
        check(supply, SUPPLY_RESET);
        check(rf_pd, RF_PD_RESET);
        check({lpo_mode, lpc_wake, io_wake}, 4'h0);
        $display("test reset done");
        // Radio power-down table, one edge of latency
        foreach (rows[i])
        begin
            @(posedge clk);
            sw_pd <= rows[i].sw;
            bb.set_rf(rows[i].bb, rows[i].ctl);
            tick(1);
            check(rf_pd, rows[i].exp);
        end
        $display("test radio table done");
        // Both request sources step down; wake skips idle
        pulse_sw(2'h2);
        check(state, PMM_IDLE);
        bb.pulse_req(2'h2);
        #1;
        check(state, PMM_SLEEP);
        bb.pulse_req(2'h1);
        #1;
        check(state, PMM_ACTIVE);
        repeat (3) pulse_sw(2'h2);
        check(state, PMM_DEEP_OFF);
        check(supply, 4'h1);
        check(rf_pd, RF_PD_ALL);
        pulse_sw(2'h2);
        check(state, PMM_DEEP_OFF);
        $display("test requests done");
        // User event wakes from deep off straight to active
        @(posedge clk);
        usr_evt <= 1'h1;
        wait_state(PMM_ACTIVE, n);
        check(io_wake, 1'h1);
        check(supply, SUPPLY_RESET);
        tick(1);
        check(io_wake, 1'h0);
        @(posedge clk);
        usr_evt <= 1'h0;
        $display("test io wake done");
        // Inactivity timer steps down each full period, restarting per state
        @(posedge clk);
        fw_off <= 1'h1;
        period <= 24'h000005;
        wait_state(PMM_IDLE, n);
        wait_state(PMM_SLEEP, n);
        check(n[3:0], 4'(P_SHORT + 1));
        wait_state(PMM_DEEP_OFF, n);
        check(n[3:0], 4'(P_SHORT + 1));
        check(supply, 4'h0);
        @(posedge clk);
        period <= 24'hFFFFFF;
        pulse_sw(2'h1);
        check(state, PMM_ACTIVE);
        $display("test inactivity timer done");
        // Low-power connection mode wakes itself after its tick count
        @(posedge clk);
        lpc_en <= 1'h1;
        @(posedge clk);
        lpc_en <= 1'h0;
        n = 0;
        while (lpo_mode !== 1'h1 && n < 3)
        begin
            tick(1);
            n++;
        end
        check(lpo_mode, 1'h1);
        n = 0;
        while (lpc_wake !== 1'h1 && n < (WAKE_TICKS + 1) * LPO_DIV_CYCLES)
        begin
            tick(1);
            n++;
        end
        check(lpc_wake, 1'h1);
        check(lpo_mode, 1'h0);
        check(n > (WAKE_TICKS - 1) * LPO_DIV_CYCLES - 4, 1'h1);
        check(n <= WAKE_TICKS * LPO_DIV_CYCLES + 4, 1'h1);
        tick(1);
        check(lpc_wake, 1'h0);
        $display("test low-power connection done");
        // Reset in mid-run from deep off must bring back the reset values
        repeat (3) pulse_sw(2'h2);
        check(state, PMM_DEEP_OFF);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        tick(1);
        check(state, PMM_ACTIVE);
        check(rf_pd, RF_PD_RESET);
        check(supply, SUPPLY_RESET);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
